// File: eise_link_if.sv
// link between the memory/io unit and the requester encoder logic
// assumes both ends run on the same clock; no clocking block here
interface eise_link_if;

  // combined active-low request, source id pins, port 0 read strobe
  logic                     external_request_input_n;
  logic [eise_pkg::ID_W-1:0] source_id;
  logic                     port0_read;

  modport unit (
    input  external_request_input_n,
    input  source_id,
    output port0_read
  );

  modport requester (
    output external_request_input_n,
    output source_id,
    input  port0_read
  );

endinterface

// File: eise_link_properties.sv
// checker for the unit/requester link and the unit's user side
// assumes one clock domain; instantiated beside the link interface
module eise_link_properties (
  // clock and reset
  input wire logic                      clock_i,
  input wire logic                      reset_n_i,
  // link signals
  input wire logic                      external_request_input_n,
  input wire logic [eise_pkg::ID_W-1:0] source_id,
  input wire logic                      port0_read,
  // unit user side
  input wire logic                      external_restart_input_i,
  input wire logic                      io_rd_i,
  input wire logic [7:0]                io_addr_i,
  input wire logic                      io_rvalid_o,
  input wire logic [7:0]                io_rdata_o,
  input wire logic                      ack_i,
  input wire logic                      irq_o,
  input wire logic                      vector_valid_o,
  input wire logic                      fetch_valid_o,
  input wire logic [15:0]               fetch_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // link properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  // id may only move around a port 0 read, never mid-request
  a_id_held_stable: assert property (
    !external_request_input_n && $past(!external_request_input_n) &&
    !$past(port0_read) && !$past(port0_read, 2) |-> $stable(source_id))
    else $error("source id moved while request held");
  // the id bits must show through the latch on pins 2..7
  a_port0_has_id: assert property (
    io_rvalid_o && port0_read && $stable(source_id) |->
    (io_rdata_o[7:2] | source_id) == io_rdata_o[7:2])
    else $error("port 0 read lost id bits");
  a_read_strobe_seen: assert property (
    io_rd_i && io_addr_i == eise_pkg::PORT0_ADDR |-> ##[1:2] port0_read)
    else $error("port 0 read not signalled");

  // ---------------------------------------------------------------
  // interrupt and restart properties
  // ---------------------------------------------------------------
  a_ack_drops_irq: assert property (
    irq_o && ack_i |=> !irq_o && vector_valid_o)
    else $error("acknowledge did not vector");
  a_vector_has_cause: assert property (
    vector_valid_o |-> $past(irq_o) && $past(ack_i))
    else $error("vector without acknowledge");
  a_fetch_from_zero: assert property (
    fetch_valid_o |-> fetch_addr_o == eise_pkg::RESTART_ADDR)
    else $error("restart fetch not at zero");
  a_restart_fetch: assert property (
    $fell(external_restart_input_i) |-> ##[1:5] fetch_valid_o)
    else $error("no fetch after restart");
  a_restart_quiet: assert property (
    external_restart_input_i [*5] |-> !irq_o && !vector_valid_o)
    else $error("activity during restart");

  // main scenarios reached
  c_ack: cover property (irq_o && ack_i);
  c_fetch: cover property (fetch_valid_o);
  c_port0: cover property (port0_read && !external_request_input_n);
endmodule

// File: eise_pkg.sv
// shared constants for the external request source encoder pair
// assumes one 100 MHz clock and a synchronous active-low reset everywhere
//
// Functional notes
// RULE_01 - only timer or external request enabled, never both
// RULE_02 - missed timeout stays pending; timer reloads meanwhile
// RULE_03 - restart input resets all, fetch from zero; requester is not reset, keeps its held id
// RULE_04 - requesters assert low, entered by falling edge; unit enters on the low level
// RULE_05 - all requester lines ANDed into one request
// RULE_06 - six high-true id lines, lsb first
// RULE_07 - id on port 0 pins 2-7, pins 0-1 low
// RULE_08 - port 0 reads four times requester number
// RULE_09 - up to 64 requesters share one input
// RULE_10 - acknowledge jumps to fixed external vector
// RULE_11 - scheme runs timer off, external permanently on
// RULE_12 - response is unit delay plus processor delay
// RULE_13 - priority among requesters resolved by encoder
// RULE_14 - unit memory at 0000-03FF, no overlap
// RULE_15 - port addresses free but never shared
// RULE_16 - port read ORs pins with latch; clear first
// RULE_17 - four consecutive ports, base ends 00, not 0/1
// RULE_18 - id held from request until port 0 read
package eise_pkg;

  // ----------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------
  localparam int ID_W        = 6;   // RULE_06
  localparam int REQ_COUNT   = 64;  // RULE_09
  localparam int LOCAL_PORTS = 4;

  // ----------------------------------------------------------------
  // i/o port map
  // ----------------------------------------------------------------
  localparam logic [7:0] PORT0_ADDR     = 8'h00;
  localparam logic [7:0] PORT_BASE_ADDR = 8'h04; // RULE_17
  localparam logic [7:0] ICR_ADDR       = 8'h0C; // RULE_15
  localparam logic [7:0] RELOAD_ADDR    = 8'h0D;
  localparam logic [7:0] STATUS_ADDR    = 8'h0E;

  // ----------------------------------------------------------------
  // interrupt control codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] ICR_OFF      = 2'h0;
  localparam logic [1:0] ICR_EXT      = 2'h1;
  localparam logic [1:0] ICR_OFF_ALT  = 2'h2;
  localparam logic [1:0] ICR_TIMER    = 2'h3;
  localparam logic [1:0] ICR_RESET    = ICR_EXT;   // RULE_11
  localparam logic [7:0] RELOAD_RESET = 8'h0_0FF;

  // ----------------------------------------------------------------
  // memory map and restart
  // ----------------------------------------------------------------
  localparam logic [15:0] RESTART_ADDR = 16'h0000; // RULE_03
  localparam logic [15:0] UNIT_MEM_LO  = 16'h0000; // RULE_14
  localparam logic [15:0] UNIT_MEM_HI  = 16'h03FF; // RULE_14

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 10;
  localparam int TICK_NS     = 1000;   // timer step time
  localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;

endpackage

// File: eise_requester.sv
// requester side: synchronises, combines and encodes request lines
// assumes request lines are asynchronous pins, active low
module eise_requester #(
  parameter int N = eise_pkg::REQ_COUNT  // RULE_09
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  // requester lines, active low
  input  wire logic [N-1:0] request_n_i,
  // link to the unit
  eise_link_if.requester    link
);

  logic [N-1:0]              req_s1_q;
  logic [N-1:0]              req_s2_q;
  logic                      comb_n_q;
  logic                      held_q;
  logic [eise_pkg::ID_W-1:0] id_q;

  // lowest numbered active requester wins
  function automatic logic [eise_pkg::ID_W-1:0] pick(
    input logic [N-1:0] v
  );
    logic [eise_pkg::ID_W-1:0] r;
    r = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (!v[i]) begin
        r = eise_pkg::ID_W'(i);  // RULE_13
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  // two stages before anything looks at the pins
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      req_s1_q <= '1;
      req_s2_q <= '1;
    end else begin
      req_s1_q <= request_n_i;  // RULE_04
      req_s2_q <= req_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // combined request
  // ----------------------------------------------------------------
  // any single low line pulls the combined request low
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      comb_n_q <= 1'b1;
    end else begin
      comb_n_q <= &req_s2_q;  // RULE_05
    end
  end

  // ----------------------------------------------------------------
  // source id capture and hold
  // ----------------------------------------------------------------
  // id is frozen so the handler never reads a torn value
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      held_q <= 1'b0;
      id_q   <= '0;
    end else if (held_q) begin
      if (link.port0_read) begin
        held_q <= 1'b0;  // RULE_18
      end
    end else if (!(&req_s2_q)) begin
      held_q <= 1'b1;
      id_q   <= pick(req_s2_q);  // RULE_06
    end
  end

  assign link.external_request_input_n = comb_n_q;
  assign link.source_id                = id_q;  // RULE_07

endmodule

// File: eise_unit.sv
// memory/io unit end: interrupt control, timer, port 0 and restart
// assumes the link peer runs on clock_i; restart arrives from a pin
module eise_unit #(
  parameter logic [15:0] EXT_VECTOR   = 16'h0_200,
  parameter logic [15:0] TIMER_VECTOR = 16'h0_280
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic        external_restart_input_i,
  // link to the requester logic
  eise_link_if.unit        link,
  // processor i/o access
  input  wire logic        io_wr_i,
  input  wire logic        io_rd_i,
  input  wire logic [7:0]  io_addr_i,
  input  wire logic [7:0]  io_wdata_i,
  output logic      [7:0]  io_rdata_o,
  output logic             io_rvalid_o,
  // interrupt to processor
  input  wire logic        ack_i,
  output logic             irq_o,
  output logic      [15:0] vector_o,
  output logic             vector_valid_o,
  // fetch restart and memory select
  input  wire logic [15:0] mem_addr_i,
  output logic      [15:0] fetch_addr_o,
  output logic             fetch_valid_o,
  output logic             mem_hit_o,
  // local port pins
  output logic      [7:0]  port_out_o [eise_pkg::LOCAL_PORTS]
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ
  } eise_irq_state_t;

  eise_irq_state_t state_q;
  logic            rst_s1_q;
  logic            rst_s2_q;
  logic            sys_rst;
  logic            boot_q;
  logic [1:0]      icr_q;
  logic [7:0]      reload_q;
  logic [7:0]      count_q;
  logic [$clog2(eise_pkg::TICK_CYCLES+1)-1:0] div_q;
  logic            tick;
  logic            timeout;
  logic            pend_q;
  logic            src_timer_q;
  logic            ext_en;
  logic            tmr_en;
  logic            ext_active;
  logic [7:0]      port0_q;
  logic [7:0]      port0_pins;
  logic [7:0]      ports_q [eise_pkg::LOCAL_PORTS];
  logic            local_hit;
  logic [1:0]      local_idx;
  logic [7:0]      rdata_d;
  logic            ack_now;
  logic            rd0_q;

  // ----------------------------------------------------------------
  // restart synchroniser and system reset
  // ----------------------------------------------------------------
  // restart is a pin, so it is synchronised before it resets anything
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= external_restart_input_i;
      rst_s2_q <= rst_s1_q;
    end
  end

  assign sys_rst = !reset_n_i || rst_s2_q;  // RULE_03

  // one fetch at address zero after every reset or restart
  always_ff @(posedge clock_i) begin
    if (sys_rst) begin
      boot_q        <= 1'b1;
      fetch_valid_o <= 1'b0;
      fetch_addr_o  <= eise_pkg::RESTART_ADDR;  // RULE_03
    end else begin
      boot_q        <= 1'b0;
      fetch_valid_o <= boot_q;
      fetch_addr_o  <= eise_pkg::RESTART_ADDR;
    end
  end

  // memory window of this unit
  always_ff @(posedge clock_i) begin
    if (sys_rst) begin
      mem_hit_o <= 1'b0;
    end else begin
      mem_hit_o <= (mem_addr_i >= eise_pkg::UNIT_MEM_LO)
                && (mem_addr_i <= eise_pkg::UNIT_MEM_HI);  // RULE_14
    end
  end

  // ----------------------------------------------------------------
  // interrupt control
  // ----------------------------------------------------------------
  // one two-bit code can only name one source, so never both enabled
  assign ext_en = (icr_q == eise_pkg::ICR_EXT);    // RULE_01
  assign tmr_en = (icr_q == eise_pkg::ICR_TIMER);  // RULE_01
  assign ext_active = ext_en && !link.external_request_input_n;

  always_ff @(posedge clock_i) begin
    if (sys_rst) begin
      icr_q <= eise_pkg::ICR_RESET;  // RULE_11
    end else if (io_wr_i && io_addr_i == eise_pkg::ICR_ADDR) begin
      icr_q <= io_wdata_i[1:0];  // RULE_01
    end
  end

  // ----------------------------------------------------------------
  // programmable timer
  // ----------------------------------------------------------------
  // divider gives a one-cycle step enable; no second clock
  always_ff @(posedge clock_i) begin
    if (sys_rst || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign tick    = (div_q == ($bits(div_q))'(eise_pkg::TICK_CYCLES - 1));
  assign timeout = tick && (count_q == 8'h0_000);

  always_ff @(posedge clock_i) begin
    if (sys_rst) begin
      reload_q <= eise_pkg::RELOAD_RESET;
    end else if (io_wr_i && io_addr_i == eise_pkg::RELOAD_ADDR) begin
      reload_q <= io_wdata_i;
    end
  end

  // keeps counting whether or not its interrupt is enabled
  always_ff @(posedge clock_i) begin
    if (sys_rst) begin
      count_q <= eise_pkg::RELOAD_RESET;
    end else if (timeout) begin
      count_q <= reload_q;  // RULE_02
    end else if (tick) begin
      count_q <= count_q - 1'b1;
    end
  end

  // pending survives a disabled interrupt; a new timeout beats the clear
  always_ff @(posedge clock_i) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
    end else if (timeout) begin
      pend_q <= 1'b1;  // RULE_02
    end else if (ack_now && src_timer_q) begin
      pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // request and acknowledge sequence
  // ----------------------------------------------------------------
  assign ack_now = (state_q == ST_REQ) && ack_i;

  // unit adds one cycle; the processor adds its own latency on top
  always_ff @(posedge clock_i) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      irq_o       <= 1'b0;
      src_timer_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (tmr_en && pend_q) begin
            state_q     <= ST_REQ;
            irq_o       <= 1'b1;  // RULE_12
            src_timer_q <= 1'b1;
          end else if (ext_active) begin
            state_q     <= ST_REQ;
            irq_o       <= 1'b1;  // RULE_12
            src_timer_q <= 1'b0;
          end
        end
        ST_REQ: begin
          if (ack_i) begin
            state_q <= ST_IDLE;
            irq_o   <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          irq_o   <= 1'b0;
        end
      endcase
    end
  end

  // vector is presented for one cycle after the acknowledge
  always_ff @(posedge clock_i) begin
    if (sys_rst) begin
      vector_o       <= 16'h0_000;
      vector_valid_o <= 1'b0;
    end else begin
      vector_valid_o <= ack_now;
      if (ack_now) begin
        vector_o <= src_timer_q ? TIMER_VECTOR : EXT_VECTOR;  // RULE_10
      end
    end
  end

  // ----------------------------------------------------------------
  // i/o ports
  // ----------------------------------------------------------------
  // id sits above two zero bits, so the read is four times the number
  assign port0_pins = {link.source_id, 2'b00};  // RULE_07 RULE_08

  assign local_hit = (io_addr_i[7:2] == eise_pkg::PORT_BASE_ADDR[7:2]);
  assign local_idx = io_addr_i[1:0];  // RULE_17

  always_ff @(posedge clock_i) begin
    if (sys_rst) begin
      port0_q <= 8'h0_000;
    end else if (io_wr_i && io_addr_i == eise_pkg::PORT0_ADDR) begin
      port0_q <= io_wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst) begin
      for (int i = 0; i < eise_pkg::LOCAL_PORTS; i++) begin
        ports_q[i] <= 8'h0_000;
      end
    end else if (io_wr_i && local_hit) begin
      ports_q[local_idx] <= io_wdata_i;
    end
  end

  // pins are ORed into the latch, so software clears port 0 first
  // every address decodes to at most one source
  always_comb begin  // RULE_15
    rdata_d = 8'h0_000;
    if (io_addr_i == eise_pkg::PORT0_ADDR) begin
      rdata_d = port0_q | port0_pins;  // RULE_16
    end else if (local_hit) begin
      rdata_d = ports_q[local_idx];
    end else if (io_addr_i == eise_pkg::ICR_ADDR) begin
      rdata_d = {6'h00, icr_q};
    end else if (io_addr_i == eise_pkg::RELOAD_ADDR) begin
      rdata_d = reload_q;
    end else if (io_addr_i == eise_pkg::STATUS_ADDR) begin
      rdata_d = {5'h00, pend_q, irq_o, !link.external_request_input_n};
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst) begin
      io_rdata_o  <= 8'h0_000;
      io_rvalid_o <= 1'b0;
      rd0_q       <= 1'b0;
    end else begin
      io_rvalid_o <= io_rd_i;
      rd0_q       <= io_rd_i && io_addr_i == eise_pkg::PORT0_ADDR;
      if (io_rd_i) begin
        io_rdata_o <= rdata_d;
      end
    end
  end

  // tells the encoder its id has been taken
  assign link.port0_read = rd0_q;  // RULE_18

  // local port pins come straight from their latches
  always_comb begin
    for (int i = 0; i < eise_pkg::LOCAL_PORTS; i++) begin
      port_out_o[i] = ports_q[i];
    end
  end

endmodule

// File: ext_interrupt_source_encoder_tb.sv
// testbench joining requester and unit over the link interface
// assumes package constants; timer runs at its full 100-cycle step
module ext_interrupt_source_encoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic        clock_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        restart = 1'b0;
  logic [63:0] req_n = '1;
  logic        io_wr_i = 1'b0;
  logic        io_rd_i = 1'b0;
  logic [7:0]  io_addr_i = 8'h00;
  logic [7:0]  io_wdata_i = 8'h00;
  logic        ack_i = 1'b0;
  logic [15:0] mem_addr_i = 16'h0000;
  logic [7:0]  io_rdata_o;
  logic        io_rvalid_o;
  logic        irq_o;
  logic [15:0] vector_o;
  logic        vector_valid_o;
  logic [15:0] fetch_addr_o;
  logic        fetch_valid_o;
  logic        mem_hit_o;
  logic [7:0]  port_out_o [eise_pkg::LOCAL_PORTS];
  logic [7:0]  q;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // device, second low line (or -1) and port 0 latch per case
  int          dev [6] = '{0, 1, 3, 5, 63, 4};
  int          oth [6] = '{-1, -1, -1, -1, -1, 9};
  logic [7:0]  lat [6] = '{8'h00, 8'h00, 8'h03, 8'h01, 8'h00, 8'h00};

  // vectors are fixed here so the expectations do not lean on defaults
  localparam logic [15:0] EXT_VEC = 16'h0200;
  localparam logic [15:0] TMR_VEC = 16'h0280;

  always #5 clock_i = ~clock_i;

  eise_link_if link ();
  eise_requester #(.N(eise_pkg::REQ_COUNT)) eise_requester_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .request_n_i(req_n),
    .link(link));
  eise_unit #(.EXT_VECTOR(EXT_VEC), .TIMER_VECTOR(TMR_VEC)) eise_unit_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i),
    .external_restart_input_i(restart), .link(link),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .io_rvalid_o(io_rvalid_o), .ack_i(ack_i), .irq_o(irq_o),
    .vector_o(vector_o), .vector_valid_o(vector_valid_o),
    .mem_addr_i(mem_addr_i), .fetch_addr_o(fetch_addr_o),
    .fetch_valid_o(fetch_valid_o), .mem_hit_o(mem_hit_o),
    .port_out_o(port_out_o));
  eise_link_properties props_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i),
    .external_request_input_n(link.external_request_input_n),
    .source_id(link.source_id), .port0_read(link.port0_read),
    .external_restart_input_i(restart), .io_rd_i(io_rd_i),
    .io_addr_i(io_addr_i), .io_rvalid_o(io_rvalid_o),
    .io_rdata_o(io_rdata_o), .ack_i(ack_i), .irq_o(irq_o),
    .vector_valid_o(vector_valid_o), .fetch_valid_o(fetch_valid_o),
    .fetch_addr_o(fetch_addr_o));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // every drive lands 1 ns after an edge, away from sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // trailing idle cycle keeps back-to-back strobes apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = 1'b1;
    tick(1);
    io_wr_i = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    io_addr_i = a;
    io_rd_i = 1'b1;
    tick(1);
    io_rd_i = 1'b0;
    for (int i = 0; i < 3 && io_rvalid_o !== 1'b1; i++) tick(1);
    d = io_rdata_o;
    chk(io_rvalid_o, 1'b1);
    tick(1);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 10 && irq_o !== 1'b1; i++) tick(1);
  endtask
  task automatic ack(input logic [15:0] v);
    ack_i = 1'b1;
    tick(1);
    ack_i = 1'b0;
    chk(vector_valid_o, 1'b1);
    tick(1);
    chk(irq_o, 1'b0);
    chk(vector_o, v);
  endtask
  task automatic close_out();
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard: the timer wait alone is about 26000 cycles
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    tick(12);
    reset_n_i = 1'b1;
    tick(2);
    for (int k = 0; k < 6; k++) begin
      wr(eise_pkg::PORT0_ADDR, lat[k]);
      req_n[dev[k]] = 1'b0;
      if (oth[k] >= 0) req_n[oth[k]] = 1'b0;
      wait_irq();
      chk(irq_o, 1'b1);
      chk(link.external_request_input_n, 1'b0);
      chk(link.source_id, 16'(dev[k]));
      req_n = '1;
      tick(5);
      ack(EXT_VEC);
      rd(eise_pkg::PORT0_ADDR, q);
      chk(q, 16'(dev[k] * 4) | lat[k]);
      tick(5);
      chk(link.external_request_input_n, 1'b1);
    end
    // timeout while external mode leaves the timer pending
    tick(26000);
    chk(irq_o, 1'b0);
    rd(eise_pkg::STATUS_ADDR, q);
    chk(q[2], 1'b1);
    wr(eise_pkg::ICR_ADDR, {6'h00, eise_pkg::ICR_TIMER});
    wait_irq();
    chk(irq_o, 1'b1);
    ack(TMR_VEC);
    rd(eise_pkg::STATUS_ADDR, q);
    chk(q[2], 1'b0);
    // both disabled: a request is captured but not raised
    wr(eise_pkg::ICR_ADDR, {6'h00, eise_pkg::ICR_OFF});
    req_n[1] = 1'b0;
    tick(10);
    chk(irq_o, 1'b0);
    req_n = '1;
    restart = 1'b1;
    tick(6);
    restart = 1'b0;
    // fetch pulse stands one cycle, three edges after restart drops
    tick(3);
    chk(fetch_valid_o, 1'b1);
    chk(fetch_addr_o, 16'h0000);
    tick(3);
    rd(eise_pkg::ICR_ADDR, q);
    chk(q[1:0], eise_pkg::ICR_RESET);
    rd(eise_pkg::PORT0_ADDR, q);
    chk(q, 8'h04);
    wr(eise_pkg::PORT_BASE_ADDR, 8'hA5);
    rd(eise_pkg::PORT_BASE_ADDR, q);
    chk(q, 8'hA5);
    chk(port_out_o[0], 8'hA5);
    rd(8'h20, q);
    chk(q, 8'h00);
    mem_addr_i = 16'h03FF;
    tick(2);
    chk(mem_hit_o, 1'b1);
    mem_addr_i = 16'h0400;
    tick(2);
    chk(mem_hit_o, 1'b0);
    close_out();
  end
endmodule
